//--- cpe_top.sv
`timescale 1ns/100ps
// How it works
// - Accumulate modulator bits into a multi-bit value
// - PWM from code versus ramp count
// - Average over slots of about 50 ms
// - Zero current gives half duty plus half a step
// - Positive current gives duty above half
// - Negative current gives duty below half
// - Full scale gives 95.5 or 4.5 percent
// - Duty linear in current, gain 1/2.2
// - Full scale build option changes neither code nor decode
// - Duty quantized to 1024 levels
// - Half-step extra high time on output
// - Each period shows previous slot's average
// - Inhibit low stops block, high runs
// - PWM period near 20 Hz from clock
module cpe_top #(
    parameter int unsigned STEP_CYCLES    = cpe_pkg::STEP_CYCLES,
    parameter bit          FULL_SCALE_10A = 1'b0
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic clk_en_i,
    input  wire logic mod_bit_i,
    input  wire logic low_power_inhibit_n_i,
    output logic      pwm_o,
    output logic      active_o
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Full-scale choice only feeds the check below, code math and reader decode are shared
    localparam int unsigned FULL_SCALE_A = FULL_SCALE_10A ? 10 : 1;
    // Last cycle count of one PWM period
    localparam logic [31:0] PERIOD_LAST = 32'(STEP_CYCLES * cpe_pkg::RAMP_LEVELS - 1);

    // Prescaler needs two states to mark a half step
    if (STEP_CYCLES < 2) begin : g_bad_step
        $error("cpe_top: STEP_CYCLES must be at least 2");
    end
    // Full scale option must name a real range
    if (FULL_SCALE_A == 0) begin : g_bad_scale
        $error("cpe_top: bad full scale");
    end
    // One PWM period may not outlast a sampling slot
    if (STEP_CYCLES * cpe_pkg::RAMP_LEVELS > cpe_pkg::SLOT_CYCLES) begin : g_bad_period
        $error("cpe_top: ramp period exceeds slot");
    end
    // Ramp levels must match the code width
    if (cpe_pkg::RAMP_LEVELS != (1 << cpe_pkg::CODE_W)) begin : g_bad_levels
        $error("cpe_top: ramp levels do not match code width");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic               mod_meta_q;
    logic               mod_sync_q;
    logic               inh_meta_q;
    logic               inh_sync_q;
    logic               clear;
    logic [10:0]        acc_q;
    logic [10:0]        ones;
    logic               load;
    logic [9:0]         code;
    cpe_pkg::cpe_ramp_t rs;
    logic [31:0]        per_cnt_q;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mod_meta_q <= 1'b0;
            mod_sync_q <= 1'b0;
            inh_meta_q <= 1'b0;
            inh_sync_q <= 1'b0;
        end else if (clk_en_i) begin
            mod_meta_q <= mod_bit_i;
            mod_sync_q <= mod_meta_q;
            inh_meta_q <= low_power_inhibit_n_i;
            inh_sync_q <= inh_meta_q;
        end
    end

    // Shutdown holds ramp, accumulator and PWM cleared and code at mid scale, synchronisers keep sampling
    assign clear = !inh_sync_q;

    // ------------------------------------------------------------
    // Ramp and step timing
    // ------------------------------------------------------------
    cpe_ramp #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_ramp (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .clk_en_i  (clk_en_i),
        .clear_i   (clear),
        .ramp_o    (rs)
    );

    // ------------------------------------------------------------
    // Slot accumulator, one sample per step
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q <= 11'h000;
        end else if (clk_en_i) begin
            if (clear) begin
                acc_q <= 11'h000;
            end else if (rs.wrap) begin
                acc_q <= 11'h000;
            end else if (rs.step) begin
                acc_q <= acc_q + {10'h000, mod_sync_q};
            end
        end
    end

    // Slot total includes the last sample
    assign ones = acc_q + {10'h000, mod_sync_q};
    assign load = rs.wrap && !clear;

    // ------------------------------------------------------------
    // Scaling to code
    // ------------------------------------------------------------
    cpe_scale u_scale (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .clk_en_i  (clk_en_i),
        .clear_i   (clear),
        .load_i    (load),
        .ones_i    (ones),
        .code_o    (code)
    );

    // ------------------------------------------------------------
    // PWM compare with half-step extension
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwm_o <= 1'b0;
        end else if (clk_en_i) begin
            if (clear) begin
                pwm_o <= 1'b0;
            end else begin
                pwm_o <= (rs.ramp < code)
                      || ((rs.ramp == code) && !rs.half);
            end
        end
    end

    // Running status
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_o <= 1'b0;
        end else if (clk_en_i) begin
            active_o <= inh_sync_q;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Cycles since the last wrap, checked against one PWM period
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            per_cnt_q <= 32'h0000_0000;
        end else if (clk_en_i) begin
            if (clear || rs.wrap) begin
                per_cnt_q <= 32'h0000_0000;
            end else begin
                per_cnt_q <= per_cnt_q + 32'h0000_0001;
            end
        end
    end

    property p_shutdown_low;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && clear) |=> !pwm_o && !active_o;
    endproperty
    a_shutdown_low: assert property (p_shutdown_low)
        else $error("pwm not low in shutdown");

    property p_wake_mid;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(active_o) |-> (code == cpe_pkg::CODE_MID) && (rs.ramp == 10'h000);
    endproperty
    a_wake_mid: assert property (p_wake_mid)
        else $error("no mid code after wake");

    property p_high_below;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && !clear && (rs.ramp < code)) |=> pwm_o;
    endproperty
    a_high_below: assert property (p_high_below)
        else $error("pwm low below code");

    property p_low_above;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && !clear && (rs.ramp > code)) |=> !pwm_o;
    endproperty
    a_low_above: assert property (p_low_above)
        else $error("pwm high above code");

    property p_half_step;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && !clear && (rs.ramp == code)) |=> (pwm_o == !$past(rs.half));
    endproperty
    a_half_step: assert property (p_half_step)
        else $error("half step wrong");

    property p_load_code;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && load) |=> (code == cpe_pkg::cpe_code_of($past(ones)));
    endproperty
    a_load_code: assert property (p_load_code)
        else $error("code not loaded at slot end");

    property p_zero_mid;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && load && (ones == cpe_pkg::COUNT_MID)) |=> (code == cpe_pkg::CODE_MID);
    endproperty
    a_zero_mid: assert property (p_zero_mid)
        else $error("zero current not mid");

    property p_pos;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && load && (ones > cpe_pkg::COUNT_MID)) |=> (code > cpe_pkg::CODE_MID);
    endproperty
    a_pos: assert property (p_pos)
        else $error("positive current not above half");

    property p_neg;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && load && (ones < cpe_pkg::COUNT_MID)) |=> (code < cpe_pkg::CODE_MID);
    endproperty
    a_neg: assert property (p_neg)
        else $error("negative current not below half");

    property p_full_scale;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && load && ((ones == cpe_pkg::COUNT_FULL) || (ones == 11'h000)))
        |=> ((code == cpe_pkg::CODE_POS_FS) || (code == cpe_pkg::CODE_NEG_FS));
    endproperty
    a_full_scale: assert property (p_full_scale)
        else $error("full scale code wrong");

    property p_slot_clear;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && rs.wrap) |=> (acc_q == 11'h000) && (rs.ramp == 10'h000);
    endproperty
    a_slot_clear: assert property (p_slot_clear)
        else $error("slot not restarted");

    property p_freeze;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !clk_en_i |=> $stable(acc_q) && $stable(pwm_o) && $stable(code);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while disabled");

    property p_period_len;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && !clear && rs.wrap) |-> (per_cnt_q == PERIOD_LAST);
    endproperty
    a_period_len: assert property (p_period_len)
        else $error("pwm period length wrong");

    property p_step_gap;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && rs.step) |=> !rs.step;
    endproperty
    a_step_gap: assert property (p_step_gap)
        else $error("ramp steps back to back");

    property p_ramp_step;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && !clear && rs.step && !rs.wrap) |=> (rs.ramp == $past(rs.ramp) + 10'h001);
    endproperty
    a_ramp_step: assert property (p_ramp_step)
        else $error("ramp did not advance one level");

    property p_acc_add;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && !clear && rs.step && !rs.wrap)
        |=> (acc_q == $past(acc_q) + {10'h000, $past(mod_sync_q)});
    endproperty
    a_acc_add: assert property (p_acc_add)
        else $error("sample not accumulated");

    property p_clear_state;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && clear) |=> (code == cpe_pkg::CODE_MID) && (acc_q == 11'h000);
    endproperty
    a_clear_state: assert property (p_clear_state)
        else $error("shutdown left state behind");

    property p_code_range;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (code >= cpe_pkg::CODE_NEG_FS) && (code <= cpe_pkg::CODE_POS_FS);
    endproperty
    a_code_range: assert property (p_code_range)
        else $error("code beyond full scale");

    property p_active_follow;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        clk_en_i |=> (active_o == $past(inh_sync_q));
    endproperty
    a_active_follow: assert property (p_active_follow)
        else $error("status not following inhibit");

endmodule

//--- cpe_pkg.sv
package cpe_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned PWM_HZ      = 20;
    localparam int unsigned SLOT_MS     = 50;
    localparam int unsigned SLOT_CYCLES = SLOT_MS * (CLK_HZ / 1000);
    localparam int unsigned RAMP_LEVELS = 1024;
    // Cycles per ramp step, longest time so rounded down
    localparam int unsigned STEP_CYCLES = CLK_HZ / (PWM_HZ * RAMP_LEVELS);

    // ------------------------------------------------------------
    // Codes and counts
    // ------------------------------------------------------------
    localparam int unsigned CODE_W     = 10;
    localparam logic [9:0]  CODE_MID   = 10'h200;
    localparam logic [9:0]  RAMP_TOP   = 10'h3ff;
    localparam logic [10:0] COUNT_MID  = 11'h200;
    localparam logic [10:0] COUNT_FULL = 11'h400;
    localparam logic [9:0]  CODE_POS_FS = 10'h3d1;
    localparam logic [9:0]  CODE_NEG_FS = 10'h02e;
    // Gain 1/2.2 as 931/2048
    localparam logic [11:0] GAIN       = 12'h3a3;
    localparam int unsigned GAIN_SHIFT = 11;

    // ------------------------------------------------------------
    // Ramp state carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic       step;
        logic       wrap;
        logic       half;
        logic [9:0] ramp;
    } cpe_ramp_t;

    // ------------------------------------------------------------
    // Ones count of one slot to PWM code
    // ------------------------------------------------------------
    function automatic logic [9:0] cpe_code_of(input logic [10:0] ones);
        logic signed [12:0] dev;
        logic signed [25:0] prod;
        logic signed [25:0] sum;
        dev  = $signed({1'b0, ones, 1'b0}) - $signed({2'b00, COUNT_FULL});
        prod = dev * $signed({1'b0, GAIN});
        sum  = (prod >>> GAIN_SHIFT) + $signed({16'h0000, CODE_MID});
        return sum[9:0];
    endfunction

endpackage

//--- cpe_ramp.sv
`timescale 1ns/100ps
module cpe_ramp #(
    parameter int unsigned STEP_CYCLES = cpe_pkg::STEP_CYCLES
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              clk_en_i,
    input  wire logic              clear_i,
    output cpe_pkg::cpe_ramp_t     ramp_o
);

    localparam logic [31:0] STEP_LAST = 32'(STEP_CYCLES - 1);
    localparam logic [31:0] STEP_HALF = 32'(STEP_CYCLES / 2);

    logic [31:0] div_q;
    logic [9:0]  ramp_q;
    logic        step;

    // Prescaler needs two states to mark a half step
    if (STEP_CYCLES < 2) begin : g_bad_step
        $error("cpe_ramp: STEP_CYCLES must be at least 2");
    end

    assign step = (div_q == STEP_LAST);

    // Step prescaler
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= 32'h0000_0000;
        end else if (clk_en_i) begin
            if (clear_i || step) begin
                div_q <= 32'h0000_0000;
            end else begin
                div_q <= div_q + 32'h0000_0001;
            end
        end
    end

    // Free-running ramp, one level per step
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ramp_q <= 10'h000;
        end else if (clk_en_i) begin
            if (clear_i) begin
                ramp_q <= 10'h000;
            end else if (step) begin
                ramp_q <= ramp_q + 10'h001;
            end
        end
    end

    // Ramp state out
    assign ramp_o.step = step;
    assign ramp_o.wrap = step && (ramp_q == cpe_pkg::RAMP_TOP);
    assign ramp_o.half = (div_q >= STEP_HALF);
    assign ramp_o.ramp = ramp_q;

endmodule

//--- cpe_scale.sv
`timescale 1ns/100ps
module cpe_scale (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        clk_en_i,
    input  wire logic        clear_i,
    input  wire logic        load_i,
    input  wire logic [10:0] ones_i,
    output logic      [9:0]  code_o
);

    // Code register, mid scale until a slot completes
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            code_o <= cpe_pkg::CODE_MID;
        end else if (clk_en_i) begin
            if (clear_i) begin
                code_o <= cpe_pkg::CODE_MID;
            end else if (load_i) begin
                code_o <= cpe_pkg::cpe_code_of(ones_i);
            end
        end
    end

endmodule

//--- cpe_pwm_meter.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Reader that times the PWM pin and decodes current
// ------------------------------------------------------------
module cpe_pwm_meter (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        armed_i,
    input  wire logic        pwm_i,
    output logic             valid_o,
    output logic      [31:0] high_o,
    output logic      [31:0] period_o,
    output int               cur_ma_o
);
    logic [31:0] high_q;
    logic [31:0] per_q;
    logic        prev_q;
    logic        seen_q;
    real         duty;

    // Rise to rise timing, one report per period
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        valid_o <= 1'b0;
        if (!rst_n_i || !armed_i) begin
            seen_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            prev_q <= pwm_i;
            if (pwm_i && !prev_q) begin
                if (seen_q) begin
                    high_o   <= high_q;
                    period_o <= per_q;
                    valid_o  <= 1'b1;
                    duty     = real'(high_q) / real'(per_q);
                    // Offset removed before decoding, 1 A scale
                    cur_ma_o <= $rtoi(2200.0 * (duty - 1.0 / 2048.0 - 0.5));
                end
                seen_q <= 1'b1;
                high_q <= 32'h0000_0001;
                per_q  <= 32'h0000_0001;
            end else begin
                per_q  <= per_q + 32'h0000_0001;
                high_q <= high_q + {31'h0000_0000, pwm_i};
            end
        end
    end
endmodule

//--- tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb;
    localparam int STEP = 8;
    localparam int PER  = 1024 * STEP;
    logic        sys_clk_i;
    logic        rst_n_i;
    logic        mod_bit_i = 1'b0;
    logic        inhibit_n;
    logic        clk_en;
    logic        meter_on;
    logic        pwm;
    logic        active;
    logic        valid;
    logic [31:0] high;
    logic [31:0] period;
    int          cur_ma;
    int          k_sel;
    int          cyc = 0;
    int          sum_got = 0;
    int          sum_exp = 0;
    int          n_rep = 0;
    int          mismatches;
    int          comparisons;
    int          exp_q[$];
    int          cur_q[$];

    cpe_top #(.STEP_CYCLES(STEP), .FULL_SCALE_10A(1'b0)) dut (
        .sys_clk_i             (sys_clk_i),
        .rst_n_i               (rst_n_i),
        .clk_en_i              (clk_en),
        .mod_bit_i             (mod_bit_i),
        .low_power_inhibit_n_i (inhibit_n),
        .pwm_o                 (pwm),
        .active_o              (active)
    );

    cpe_pwm_meter meter (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .armed_i   (meter_on),
        .pwm_i     (pwm),
        .valid_o   (valid),
        .high_o    (high),
        .period_o  (period),
        .cur_ma_o  (cur_ma)
    );

    // Clock
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Density pattern k of 4 steps high, plus hang guard
    always @(posedge sys_clk_i) begin
        cyc       <= cyc + 1;
        mod_bit_i <= ((cyc / STEP) % 4) < k_sel;
        if (cyc == 80000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Expected code from a slot whose ones count is 256*k
    function automatic int code_of(int k);
        int num;
        num = (512 * k - 1024) * 931;
        return 512 + (num >= 0 ? num / 2048 : -((2047 - num) / 2048));
    endfunction

    task automatic expect_slot(int k);
        k_sel <= k;
        exp_q.push_back(code_of(k));
        cur_q.push_back(k * 500 - 1000);
    endtask

    task automatic first_rise(int k);
        int n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pwm !== 1'b1 && n < 2 * PER);
        expect_slot(k);
    endtask

    task automatic take_report();
        int n = 0;
        int e_hi;
        int e_cur;
        logic ok;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (valid !== 1'b1 && n < 2 * PER);
        e_hi  = exp_q.pop_front() * STEP + STEP / 2;
        e_cur = cur_q.pop_front();
        ok    = (e_cur - cur_ma <= 3) && (cur_ma - e_cur <= 3);
        sum_got += cur_ma;
        sum_exp += e_cur;
        n_rep++;
        `CHK(high, 32'(e_hi))
        `CHK(period, 32'(PER))
        `CHK(ok, 1'b1)
    endtask

    initial begin
        int ks[4];
        int bad;
        int avg_err;
        void'($urandom(54508));
        rst_n_i   = 1'b0;
        inhibit_n = 1'b1;
        meter_on  = 1'b1;
        k_sel     = 2;
        clk_en    = 1'b1;
        mismatches  = 0;
        comparisons = 0;
        exp_q = {512};
        cur_q = {0};
        ks = '{0, 2, 1, 3};
        ks[2] = $urandom_range(3, 1);
        ks[3] = $urandom_range(3, 1);
        repeat (20) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        `CHK(active, 1'b1)
        first_rise(4);
        foreach (ks[i]) begin
            take_report();
            expect_slot(ks[i]);
        end
        take_report();
        // Freeze with inhibit low, then shutdown in mid-period
        inhibit_n <= 1'b0;
        clk_en    <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        `CHK({pwm, active}, 2'h3)
        clk_en    <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        meter_on <= 1'b0;
        `CHK({pwm, active}, 2'h0)
        bad = 0;
        repeat (50) begin
            @(posedge sys_clk_i);
            bad += (pwm !== 1'b0);
        end
        `CHK(bad, 0)
        exp_q.delete();
        cur_q.delete();
        exp_q.push_back(512);
        cur_q.push_back(0);
        inhibit_n <= 1'b1;
        meter_on  <= 1'b1;
        first_rise(3);
        take_report();
        take_report();
        // Averaged readings settle on the averaged expectation
        avg_err = (sum_got - sum_exp) / n_rep;
        bad     = (avg_err < -3) || (avg_err > 3);
        `CHK(bad, 0)
        tally_and_finish();
    end
endmodule
